// file: rmu_far_model.sv
`timescale 1ns/1ps
module rmu_far_model #(
  parameter int SUP_DLY = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supply_gen_en,
  input wire logic pin_rst_out,
  input wire logic pin_rst_oe_n,
  input wire logic press,
  output logic supply_good,
  output logic pin_rst_in
);
  int sup_cnt_ff;

  // Rails come up a few cycles after the enable and drop with it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sup_cnt_ff <= 0;
    end else if (!supply_gen_en) begin
      sup_cnt_ff <= 0;
    end else if (sup_cnt_ff < SUP_DLY) begin
      sup_cnt_ff <= sup_cnt_ff + 1;
    end
  end
  assign supply_good = (sup_cnt_ff == SUP_DLY);

  // outside press held
  // Pin has a pull-up; the device or the outside button pulls it low
  assign pin_rst_in = !pin_rst_oe_n ? pin_rst_out : !press;
endmodule

// file: rmu_pin_filt.sv
`timescale 1ns/1ps
module rmu_pin_filt (
  input wire logic mclk,
  input wire logic rst_n,
  rmu_pin_if.filt pin
);
  import rmu_pkg::*;

  logic [PIN_CNT_W-1:0] cnt_ff;
  logic [PIN_CNT_W-1:0] nxt_cnt;
  wire live_low = pin.pin_low && !pin.gate;
  wire at_stable = (cnt_ff == PIN_CNT_W'(PIN_STABLE_CYC));

  // Count consecutive low samples; saturate past the firing point
  assign nxt_cnt = !live_low ? '0 :
                   (cnt_ff > PIN_CNT_W'(PIN_STABLE_CYC)) ? cnt_ff : cnt_ff + 1'b1;
  assign pin.req = live_low && at_stable;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  pin_stable_a: assert property (@(posedge mclk) disable iff (!rst_n)
    pin.req |-> $past(pin.pin_low, 50) && $past(pin.pin_low, 25) && $past(pin.pin_low, 1))
    else $error("pin request taken before stable time");
endmodule

// file: rmu_pin_if.sv
`timescale 1ns/1ps
interface rmu_pin_if;
  logic pin_low;
  logic gate;
  logic req;
  modport filt (input pin_low, input gate, output req);
  modport ctrl (output pin_low, output gate, input req);
endinterface

// file: rmu_pkg.sv
package rmu_pkg;
  // Core clock rate in MHz
  localparam int CLK_MHZ = 100;
  // Pin request must stay low for longer than this
  localparam int PIN_STABLE_NS = 500;
  localparam int PIN_STABLE_CYC = (PIN_STABLE_NS * CLK_MHZ + 999) / 1000;
  localparam int PIN_CNT_W = 6;
  // Error counts that turn a failure into a limit event
  localparam logic [2:0] ERR_LIMIT = 3'h5;
  localparam logic [2:0] ERR_RST = 3'h0;
  // Low-power oscillator ticks between watchdog miss and core reset
  localparam logic [4:0] WDT_LP_DELAY = 5'h04;
  // Core clock cycles that a reset is held and the pin driven low
  localparam logic [4:0] RST_HOLD_CYC = 5'h10;
  localparam logic [4:0] CNT_RST = 5'h00;

  // Reset source bit positions
  localparam int SRC_POR = 0;
  localparam int SRC_SLEEP = 1;
  localparam int SRC_STOP = 2;
  localparam int SRC_PIN = 3;
  localparam int SRC_SYSTEM_WATCHDOG = 4;
  localparam int SRC_SOFT = 5;
  localparam int SRC_CPUWDT = 6;
  localparam int SRC_SUPLIM = 7;
  localparam int SRC_WDTLIM = 8;
  localparam int NSRC = 9;
  localparam int NCLASS = 5;

  // Source membership of each reset class, class 0 in the low slot
  localparam logic [NCLASS-1:0][NSRC-1:0] CLS_MASK = {
    9'h19F, 9'h1FF, 9'h1FD, 9'h181, 9'h001
  };

  // Status reset values
  localparam logic [4:0] STS1_RST = 5'h00;
  localparam logic [1:0] STS2_RST = 2'h0;

  typedef enum logic [2:0] {
    ST_WAIT = 3'h0,
    ST_PWRUP = 3'h1,
    ST_ACTIVE = 3'h3,
    ST_RST = 3'h2,
    ST_STOP = 3'h6,
    ST_SLEEP = 3'h7,
    ST_WDTW = 3'h5
  } rmu_state_t;
endpackage

// file: rmu_reset_manager.sv
// Behaviour
// - Power-on reset is master; released at battery minimum, then power-on flag.
// - After power-on run power-up sequence; core reset released last.
// - Sleep exit runs same sequence, sets sleep-exit flag instead.
// - Stop wake has no reset unless wake-with-reset enabled.
// - Stop wake with reset sets the stop-wake flag.
// - Pin reset accepted only in Active and Stop mode.
// - Pin requests blocked while another reset executes.
// - Pin request must stay low longer than 500 ns.
// - Pin request in Stop: go Active, wake core, set pin flag.
// - Other sources act only in Active mode.
// - System watchdog works only in Active; missed trigger signals us.
// - Watchdog miss sets flag, core reset after several oscillator ticks. The miss that reaches the limit sets watchdog limit source instead of flag.
// - Soft and CPU watchdog resets lowest priority, Active only.
// - Soft reset takes effect within two core cycles.
// - Soft resets processed independently of the oscillator tick.
// - Soft and CPU watchdog resets set flags in second status register.
// - Regulator failure: system reset, then Sleep, set failure flag.
// - A class register clears on any source of that class.
// - Class one: power-on, supply limit, watchdog limit only.
// - Sleep exit clears classes three and four.
// - Unclassed registers clear on every system reset.
// - Limit events fire when error count reaches 5.
// - Class zero power-on only; only classes three and four have sleep exit.
// - Class two includes stop exit with reset.
`timescale 1ns/1ps
module rmu_reset_manager (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic lp_tick,
  input wire logic batt_ok,
  input wire logic supply_good,
  input wire logic stop_req,
  input wire logic sleep_req,
  input wire logic wake_evt,
  input wire logic wake_w_rst,
  input wire logic pin_rst_in,
  input wire logic sys_wdt_miss,
  input wire logic soft_rst_req,
  input wire logic cpu_wdt_req,
  input wire logic regulator_fail,
  input wire logic [4:0] sts1_clr,
  input wire logic [1:0] sts2_clr,
  input wire logic reg_fail_clr,
  output logic pin_rst_out,
  output logic pin_rst_oe_n,
  output logic supply_gen_en,
  output logic core_rst_n,
  output logic core_wake,
  output logic [rmu_pkg::NCLASS-1:0] rst_class_clr,
  output logic sys_rst_clr,
  output logic mode_active,
  output logic mode_stop,
  output logic mode_sleep,
  output logic [4:0] reset_status_first,
  output logic [1:0] reset_status_second,
  output logic regulator_failure_flag
);
  import rmu_pkg::*;

  rmu_state_t st_ff, nxt_st;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [2:0] err_sup_ff, err_wdt_ff;
  logic [NSRC-1:0] src_ff, nxt_src;
  logic seq_sleep_ff, nxt_seq_sleep;
  logic to_sleep_ff, nxt_to_sleep;
  logic core_rst_n_ff, core_wake_ff, nxt_wake, sys_clr_ff, nxt_sys_clr;
  logic pin_oe_n_ff, gen_en_ff;
  logic [4:0] sts1_ff;
  logic [1:0] sts2_ff;
  logic rf_flag_ff;

  rmu_pin_if pin_if ();

  wire act = (st_ff == ST_ACTIVE);
  wire stp = (st_ff == ST_STOP);
  // pin accepted in Active and Stop only
  assign pin_if.gate = !(act || stp);
  assign pin_if.pin_low = !pin_rst_in;
  wire pin_req = pin_if.req;

  rmu_pin_filt u_pin_filt (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(pin_if.filt)
  );

  // watchdog misses honoured in Active only
  wire rf_hit = act && regulator_fail;
  wire wdt_hit = act && sys_wdt_miss;
  wire sup_lim = rf_hit && (err_sup_ff == ERR_LIMIT - 3'h1);
  wire wdt_lim = wdt_hit && (err_wdt_ff == ERR_LIMIT - 3'h1);
  wire hi_hit = rf_hit || pin_req || wdt_hit;
  wire sw_go = act && soft_rst_req && !hi_hit;
  wire cw_go = act && cpu_wdt_req && !soft_rst_req && !hi_hit;
  wire stop_wake = stp && wake_evt && !pin_req;
  wire hold_done = (cnt_ff == RST_HOLD_CYC - 5'h01);
  wire wdt_done = lp_tick && (cnt_ff == WDT_LP_DELAY - 5'h01);
  wire nxt_run = (nxt_st == ST_ACTIVE) || (nxt_st == ST_STOP) || (nxt_st == ST_WDTW);

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = CNT_RST;
    nxt_src = '0;
    nxt_seq_sleep = seq_sleep_ff;
    nxt_to_sleep = to_sleep_ff;
    nxt_wake = 1'b0;
    nxt_sys_clr = 1'b0;
    case (st_ff)
      // wait for battery minimum after power-on
      ST_WAIT: begin
        if (batt_ok) begin
          nxt_st = ST_PWRUP;
        end
      end
      // core released as last power-up step
      ST_PWRUP: begin
        if (supply_good) begin
          nxt_st = ST_ACTIVE;
          // sleep exit flagged instead of power-on
          nxt_src[SRC_POR] = !seq_sleep_ff;
          nxt_src[SRC_SLEEP] = seq_sleep_ff;
          nxt_sys_clr = 1'b1;
          nxt_seq_sleep = 1'b0;
        end
      end
      ST_ACTIVE: begin
        if (rf_hit) begin
          nxt_st = ST_RST;
          nxt_to_sleep = 1'b1;
          nxt_src[SRC_SUPLIM] = sup_lim;
          nxt_sys_clr = 1'b1;
        end else if (pin_req) begin
          nxt_st = ST_RST;
          nxt_src[SRC_PIN] = 1'b1;
          nxt_sys_clr = 1'b1;
        end else if (wdt_hit) begin
          // flag now, reset after oscillator ticks
          nxt_st = ST_WDTW;
          nxt_src[SRC_SYSTEM_WATCHDOG] = !wdt_lim;
          nxt_src[SRC_WDTLIM] = wdt_lim;
        end else if (sw_go || cw_go) begin
          // acted on without waiting for an oscillator tick
          nxt_st = ST_RST;
          nxt_src[SRC_SOFT] = sw_go;
          nxt_src[SRC_CPUWDT] = cw_go;
          nxt_sys_clr = 1'b1;
        end else if (sleep_req) begin
          nxt_st = ST_SLEEP;
        end else if (stop_req) begin
          nxt_st = ST_STOP;
        end
      end
      ST_STOP: begin
        if (pin_req) begin
          // wake core, flag pin, then execute reset
          nxt_st = ST_RST;
          nxt_wake = 1'b1;
          nxt_src[SRC_PIN] = 1'b1;
          nxt_sys_clr = 1'b1;
        end else if (stop_wake && wake_w_rst) begin
          nxt_st = ST_RST;
          nxt_src[SRC_STOP] = 1'b1;
          nxt_sys_clr = 1'b1;
        end else if (stop_wake) begin
          nxt_st = ST_ACTIVE;
          nxt_wake = 1'b1;
        end
      end
      ST_WDTW: begin
        nxt_cnt = lp_tick ? cnt_ff + 5'h01 : cnt_ff;
        if (wdt_done) begin
          nxt_st = ST_RST;
          nxt_cnt = CNT_RST;
          nxt_sys_clr = 1'b1;
        end
      end
      ST_RST: begin
        nxt_cnt = cnt_ff + 5'h01;
        if (hold_done) begin
          nxt_cnt = CNT_RST;
          nxt_st = to_sleep_ff ? ST_SLEEP : ST_ACTIVE;
          nxt_to_sleep = 1'b0;
        end
      end
      ST_SLEEP: begin
        if (wake_evt) begin
          nxt_st = ST_PWRUP;
          nxt_seq_sleep = 1'b1;
        end
      end
      default: begin
        nxt_st = ST_WAIT;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_WAIT;
      cnt_ff <= CNT_RST;
      src_ff <= '0;
      seq_sleep_ff <= 1'b0;
      to_sleep_ff <= 1'b0;
      core_rst_n_ff <= 1'b0;
      core_wake_ff <= 1'b0;
      sys_clr_ff <= 1'b0;
      pin_oe_n_ff <= 1'b1;
      gen_en_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      src_ff <= nxt_src;
      seq_sleep_ff <= nxt_seq_sleep;
      to_sleep_ff <= nxt_to_sleep;
      // core reset falls on the edge that takes the request
      core_rst_n_ff <= nxt_run;
      core_wake_ff <= nxt_wake;
      sys_clr_ff <= nxt_sys_clr;
      pin_oe_n_ff <= (nxt_st != ST_RST);
      gen_en_ff <= (nxt_st != ST_WAIT) && (nxt_st != ST_SLEEP);
    end
  end

  // error counters, restarted after a limit event
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      err_sup_ff <= ERR_RST;
      err_wdt_ff <= ERR_RST;
    end else begin
      if (rf_hit) begin
        err_sup_ff <= sup_lim ? ERR_RST : err_sup_ff + 3'h1;
      end
      if (wdt_hit) begin
        err_wdt_ff <= wdt_lim ? ERR_RST : err_wdt_ff + 3'h1;
      end
    end
  end

  // flags cleared only by power-on or software, set wins
  // soft and CPU watchdog flags in second register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sts1_ff <= STS1_RST;
      sts2_ff <= STS2_RST;
      rf_flag_ff <= 1'b0;
    end else begin
      sts1_ff <= (sts1_ff & ~sts1_clr) | src_ff[SRC_SYSTEM_WATCHDOG:SRC_POR];
      sts2_ff <= (sts2_ff & ~sts2_clr) | src_ff[SRC_CPUWDT:SRC_SOFT];
      rf_flag_ff <= (rf_flag_ff && !reg_fail_clr) || rf_hit;
    end
  end

  // class masks for classes zero to four
  // stop exit with reset in class two
  genvar k;
  generate
    for (k = 0; k < NCLASS; k++) begin : g_cls
      assign rst_class_clr[k] = |(src_ff & CLS_MASK[k]);
    end
  endgenerate
  // unclassed registers clear on any system reset
  assign sys_rst_clr = sys_clr_ff;

  assign pin_rst_out = 1'b0;
  assign pin_rst_oe_n = pin_oe_n_ff;
  assign supply_gen_en = gen_en_ff;
  assign core_rst_n = core_rst_n_ff;
  assign core_wake = core_wake_ff;
  assign mode_active = act;
  assign mode_stop = stp;
  assign mode_sleep = (st_ff == ST_SLEEP);
  assign reset_status_first = sts1_ff;
  assign reset_status_second = sts2_ff;
  assign regulator_failure_flag = rf_flag_ff;

  pwrup_last_a: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(core_rst_n) |-> ($past(st_ff) == ST_PWRUP) || ($past(st_ff) == ST_RST)
      || ($past(st_ff) == ST_WDTW) || ($past(st_ff) == ST_STOP))
    else $error("core reset released outside a sequence");
  soft_fast_a: assert property (@(posedge mclk) disable iff (!rst_n)
    sw_go |=> !core_rst_n && !pin_rst_oe_n ##1 reset_status_second[0])
    else $error("soft reset not applied in time");
  stop_plain_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (stop_wake && !wake_w_rst) |=> core_rst_n && core_wake && mode_active)
    else $error("plain stop wake caused a reset");
  stop_flag_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (stop_wake && wake_w_rst) |=> !core_rst_n ##1 reset_status_first[SRC_STOP])
    else $error("stop wake with reset not flagged");
  pin_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !(mode_active || mode_stop) |=> !pin_req [*8])
    else $error("pin request taken while gated");
  pin_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (stp && pin_req) |=> core_wake ##1 reset_status_first[SRC_PIN])
    else $error("pin request in stop mishandled");
  wdt_delay_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wdt_hit && !rf_hit && !pin_req) |=> core_rst_n[*4])
    else $error("watchdog reset came too early");
  limit_cls_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wdt_lim && !rf_hit && !pin_req) |=> rst_class_clr[1] && !reset_status_first[SRC_SYSTEM_WATCHDOG])
    else $error("watchdog limit did not clear class one");
  sleep_cls_a: assert property (@(posedge mclk) disable iff (!rst_n)
    src_ff[SRC_SLEEP] |-> rst_class_clr[3] && rst_class_clr[4] && !rst_class_clr[2])
    else $error("sleep exit class clears wrong");
  regfail_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rf_hit |=> regulator_failure_flag && !core_rst_n ##16 mode_sleep)
    else $error("regulator failure did not end in sleep");

  por_cov: cover property (@(posedge mclk) disable iff (!rst_n)
    src_ff[SRC_POR] ##1 reset_status_first[SRC_POR]);
  sleep_cov: cover property (@(posedge mclk) disable iff (!rst_n)
    mode_sleep ##[1:50] src_ff[SRC_SLEEP]);
  pin_cov: cover property (@(posedge mclk) disable iff (!rst_n)
    pin_req && mode_active);
endmodule

// file: test_rmu_reset_manager.sv
`timescale 1ns/1ps
module test_rmu_reset_manager;
  import rmu_pkg::*;
  typedef struct packed {
    logic stp;
    logic [3:0] kind;
    logic [4:0] cls;
    logic [4:0] s1;
    logic [1:0] s2;
    logic wk;
  } rmu_row_t;

  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic lp_tick = 1'b0;
  logic [2:0] lp_cnt = 3'h0;
  logic batt_ok, stop_req, sleep_req, wake_evt, wake_w_rst, sys_wdt_miss;
  logic soft_rst_req, cpu_wdt_req, regulator_fail, reg_fail_clr, press;
  logic [4:0] sts1_clr;
  logic [1:0] sts2_clr;
  logic supply_good, pin_rst_in, pin_rst_out, pin_rst_oe_n, supply_gen_en;
  logic core_rst_n, core_wake, sys_rst_clr, mode_active, mode_stop, mode_sleep;
  logic regulator_failure_flag;
  logic [NCLASS-1:0] rst_class_clr;
  logic [4:0] reset_status_first;
  logic [1:0] reset_status_second;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  rmu_row_t rows [10];

  always #5 mclk = ~mclk;

  always @(negedge mclk) begin
    lp_cnt <= lp_cnt + 3'h1;
    lp_tick <= (lp_cnt == 3'h7);
  end

  rmu_reset_manager dut (.mclk(mclk), .rst_n(rst_n), .lp_tick(lp_tick), .batt_ok(batt_ok),
    .supply_good(supply_good), .stop_req(stop_req), .sleep_req(sleep_req),
    .wake_evt(wake_evt), .wake_w_rst(wake_w_rst), .pin_rst_in(pin_rst_in),
    .sys_wdt_miss(sys_wdt_miss), .soft_rst_req(soft_rst_req), .cpu_wdt_req(cpu_wdt_req),
    .regulator_fail(regulator_fail), .sts1_clr(sts1_clr), .sts2_clr(sts2_clr),
    .reg_fail_clr(reg_fail_clr), .pin_rst_out(pin_rst_out), .pin_rst_oe_n(pin_rst_oe_n),
    .supply_gen_en(supply_gen_en), .core_rst_n(core_rst_n), .core_wake(core_wake),
    .rst_class_clr(rst_class_clr), .sys_rst_clr(sys_rst_clr), .mode_active(mode_active),
    .mode_stop(mode_stop), .mode_sleep(mode_sleep), .reset_status_first(reset_status_first),
    .reset_status_second(reset_status_second),
    .regulator_failure_flag(regulator_failure_flag));

  rmu_far_model far (.mclk(mclk), .rst_n(rst_n), .supply_gen_en(supply_gen_en),
    .pin_rst_out(pin_rst_out), .pin_rst_oe_n(pin_rst_oe_n), .press(press),
    .supply_good(supply_good), .pin_rst_in(pin_rst_in));

  task automatic test_done;
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Fire one source (soft and CPU watchdog together for kind 5), gather class pulses and wake, then check and clear flags
  task automatic run_case(input rmu_row_t r);
    logic [4:0] cls_or;
    logic wk_or;
    logic sc_or;
    int hold;
    cls_or = 5'h00;
    wk_or = 1'b0;
    sc_or = 1'b0;
    hold = (r.kind == 4'h4) ? 40 : 60;
    if (r.stp) begin
      stop_req = 1'b1;
      repeat (3) @(negedge mclk);
      stop_req = 1'b0;
      repeat (3) @(negedge mclk);
      chk(8'(mode_stop), 8'h01);
    end
    wake_w_rst = (r.kind == 4'h7);
    case (r.kind)
      4'h0: soft_rst_req = 1'b1;
      4'h1: cpu_wdt_req = 1'b1;
      4'h2: sys_wdt_miss = 1'b1;
      4'h3, 4'h4: press = 1'b1;
      4'h5: {soft_rst_req, cpu_wdt_req} = 2'h3;
      4'h6, 4'h7: wake_evt = 1'b1;
      4'h8: regulator_fail = 1'b1;
      default: batt_ok = 1'b1;
    endcase
    for (int i = 0; i < 120; i++) begin
      @(negedge mclk);
      {soft_rst_req, cpu_wdt_req, sys_wdt_miss, wake_evt, regulator_fail} = 5'h00;
      if (i == hold) begin
        press = 1'b0;
      end
      cls_or = cls_or | rst_class_clr;
      wk_or = wk_or | core_wake;
      sc_or = sc_or | sys_rst_clr;
    end
    chk(8'(cls_or), 8'(r.cls));
    chk(8'(reset_status_first), 8'(r.s1));
    chk(8'(reset_status_second), 8'(r.s2));
    chk(8'(sc_or), 8'((r.cls != 5'h00) || (r.kind == 4'h8)));
    if (r.wk !== 1'bx) begin
      chk(8'(wk_or), 8'(r.wk));
    end
    sts1_clr = 5'h1F;
    sts2_clr = 2'h3;
    @(negedge mclk);
    sts1_clr = 5'h00;
    sts2_clr = 2'h0;
    wake_w_rst = 1'b0;
  endtask

  always @(posedge mclk) begin
    cyc_cnt++;
    if (cyc_cnt == 10000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    {batt_ok, stop_req, sleep_req, wake_evt, wake_w_rst, sys_wdt_miss} = 6'h00;
    {soft_rst_req, cpu_wdt_req, regulator_fail, reg_fail_clr, press} = 5'h00;
    sts1_clr = 5'h00;
    sts2_clr = 2'h0;
    rows[0] = {1'b0, 4'h9, 5'h1F, 5'h01, 2'h0, 1'bx};
    rows[1] = {1'b0, 4'h0, 5'h0C, 5'h00, 2'h1, 1'bx};
    rows[2] = {1'b0, 4'h1, 5'h0C, 5'h00, 2'h2, 1'bx};
    rows[3] = {1'b0, 4'h5, 5'h0C, 5'h00, 2'h1, 1'bx};
    rows[4] = {1'b0, 4'h2, 5'h1C, 5'h10, 2'h0, 1'bx};
    rows[5] = {1'b0, 4'h3, 5'h1C, 5'h08, 2'h0, 1'bx};
    rows[6] = {1'b0, 4'h4, 5'h00, 5'h00, 2'h0, 1'b0};
    rows[7] = {1'b1, 4'h6, 5'h00, 5'h00, 2'h0, 1'b1};
    rows[8] = {1'b1, 4'h7, 5'h1C, 5'h04, 2'h0, 1'bx};
    rows[9] = {1'b1, 4'h3, 5'h1C, 5'h08, 2'h0, 1'b1};
    repeat (20) @(negedge mclk);
    rst_n = 1'b1;
    repeat (5) @(negedge mclk);
    chk(8'(core_rst_n), 8'h00);
    for (int k = 0; k < 10; k++) begin
      run_case(rows[k]);
    end
    for (int k = 0; k < 3; k++) begin
      run_case({1'b0, 4'h2, 5'h1C, 5'h10, 2'h0, 1'bx});
    end
    run_case({1'b0, 4'h2, 5'h1E, 5'h00, 2'h0, 1'bx});
    run_case({1'b0, 4'h8, 5'h00, 5'h00, 2'h0, 1'bx});
    chk(8'(regulator_failure_flag), 8'h01);
    chk(8'(mode_sleep), 8'h01);
    chk(8'(supply_gen_en), 8'h00);
    reg_fail_clr = 1'b1;
    @(negedge mclk);
    reg_fail_clr = 1'b0;
    chk(8'(regulator_failure_flag), 8'h00);
    run_case({1'b0, 4'h3, 5'h00, 5'h00, 2'h0, 1'b0});
    run_case({1'b0, 4'h0, 5'h00, 5'h00, 2'h0, 1'b0});
    run_case({1'b0, 4'h6, 5'h18, 5'h02, 2'h0, 1'bx});
    chk(8'(core_rst_n), 8'h01);
    sleep_req = 1'b1;
    @(negedge mclk);
    sleep_req = 1'b0;
    @(negedge mclk);
    chk(8'(mode_sleep), 8'h01);
    chk(8'(supply_gen_en), 8'h00);
    run_case({1'b0, 4'h6, 5'h18, 5'h02, 2'h0, 1'bx});
    run_case({1'b0, 4'h8, 5'h00, 5'h00, 2'h0, 1'bx});
    chk(8'(regulator_failure_flag), 8'h01);
    rst_n = 1'b0;
    @(negedge mclk);
    chk(8'(core_rst_n), 8'h00);
    chk(8'(regulator_failure_flag), 8'h00);
    test_done();
  end
endmodule
